/* File: pbc_pkg.sv */
// Package with register map, field layout, reset values and the register select type of the change detector.
package pbc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int PBC_ADDR_W = 8;
    localparam int PBC_DATA_W = 32;

    // ------------------------------------------------------------------
    // Port widths
    // ------------------------------------------------------------------
    // Port B has change logic only on its upper pins 7 to 4.
    localparam int PBC_B_PINS = 4;
    localparam int PBC_C_PINS = 8;
    // Low bit of the port B fields within an 8-bit register.
    localparam int PBC_B_LSB = 4;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_B_RISE = 8'h00;
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_B_FALL = 8'h04;
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_B_FLAG = 8'h08;
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_C_RISE = 8'h0C;
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_C_FALL = 8'h10;
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_C_FLAG = 8'h14;
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_STATUS = 8'h18;
    localparam logic [PBC_ADDR_W-1:0] PBC_OFF_MASK = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    // Bit of the shared change flag in the status and mask registers.
    localparam int PBC_STAT_CHANGE = 0;
    localparam logic [PBC_B_PINS-1:0] PBC_B_RESET = 4'h0;
    localparam logic [PBC_C_PINS-1:0] PBC_C_RESET = 8'h00;
    localparam logic [PBC_DATA_W-1:0] PBC_DATA_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Register selection decoded from the address
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PBC_SEL_B_RISE,
        PBC_SEL_B_FALL,
        PBC_SEL_B_FLAG,
        PBC_SEL_C_RISE,
        PBC_SEL_C_FALL,
        PBC_SEL_C_FLAG,
        PBC_SEL_STATUS,
        PBC_SEL_MASK,
        PBC_SEL_NONE
    } pbc_sel_e;

endpackage

/* File: pbc_edge_detect.sv */
// Pin synchroniser and edge detector for one group of change-detect pins.
module pbc_edge_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous pins.
    input wire logic [WIDTH-1:0] pin,
    // One-cycle edge pulses.
    output logic [WIDTH-1:0] rise_det,
    output logic [WIDTH-1:0] fall_det
);
    import pbc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic meta_ok;
        logic sync_ok;
        logic prev_ok;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } pbc_edge_s;

    pbc_edge_s r;
    pbc_edge_s next_r;

    // ------------------------------------------------------------------
    // Sampling and comparison
    // ------------------------------------------------------------------
    // synchronise then compare
    // The first stage feeds only the second; edges come from the second and
    // the previous sample. The valid bits follow the data down the chain, so
    // no edge is reported until both compared samples came from the pin and
    // a pin already high at reset release does not look like a rising edge.
    always_comb begin
        next_r = r;
        next_r.meta = pin;
        next_r.sync = r.meta;
        next_r.prev = r.sync;
        next_r.meta_ok = 1'b1;
        next_r.sync_ok = r.meta_ok;
        next_r.prev_ok = r.sync_ok;
        next_r.rise = r.prev_ok ? (r.sync & ~r.prev) : '0;
        next_r.fall = r.prev_ok ? (~r.sync & r.prev) : '0;
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rise_det = r.rise;
    assign fall_det = r.fall;

endmodule

/* File: pbc_change_detect.sv */
// Interrupt-on-change detector for port B pins 7 to 4 and port C pins 7 to 0, APB slave.
module pbc_change_detect (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pbc_pkg::PBC_ADDR_W-1:0] paddr,
    input wire logic [pbc_pkg::PBC_DATA_W-1:0] pwdata,
    output logic [pbc_pkg::PBC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins, port B bit 0 is pin 4.
    input wire logic [pbc_pkg::PBC_B_PINS-1:0] port_b_pin,
    input wire logic [pbc_pkg::PBC_C_PINS-1:0] port_c_pin,
    // Interrupt outputs.
    output logic shared_change_interrupt_flag,
    output logic irq
);
    import pbc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PBC_B_PINS-1:0] b_rise;
        logic [PBC_B_PINS-1:0] b_fall;
        logic [PBC_B_PINS-1:0] b_flag;
        logic [PBC_C_PINS-1:0] c_rise;
        logic [PBC_C_PINS-1:0] c_fall;
        logic [PBC_C_PINS-1:0] c_flag;
        logic status;
        logic mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [PBC_DATA_W-1:0] prdata;
    } pbc_regs_s;

    pbc_regs_s r;
    pbc_regs_s next_r;

    logic [PBC_B_PINS-1:0] b_rise_det;
    logic [PBC_B_PINS-1:0] b_fall_det;
    logic [PBC_C_PINS-1:0] c_rise_det;
    logic [PBC_C_PINS-1:0] c_fall_det;
    logic [PBC_B_PINS-1:0] b_rise_hit;
    logic [PBC_B_PINS-1:0] b_fall_hit;
    logic [PBC_C_PINS-1:0] c_rise_hit;
    logic [PBC_C_PINS-1:0] c_fall_hit;
    logic [PBC_B_PINS-1:0] b_hit;
    logic [PBC_C_PINS-1:0] c_hit;
    logic any_hit;
    pbc_sel_e sel;
    logic commit;
    logic wr_b_flag;
    logic wr_c_flag;
    logic wr_status;
    logic [PBC_DATA_W-1:0] read_data;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Shared by the read path and every write strobe.
    function automatic pbc_sel_e decode(input logic [PBC_ADDR_W-1:0] addr);
        pbc_sel_e s;
        case (addr)
            PBC_OFF_B_RISE: s = PBC_SEL_B_RISE;
            PBC_OFF_B_FALL: s = PBC_SEL_B_FALL;
            PBC_OFF_B_FLAG: s = PBC_SEL_B_FLAG;
            PBC_OFF_C_RISE: s = PBC_SEL_C_RISE;
            PBC_OFF_C_FALL: s = PBC_SEL_C_FALL;
            PBC_OFF_C_FLAG: s = PBC_SEL_C_FLAG;
            PBC_OFF_STATUS: s = PBC_SEL_STATUS;
            PBC_OFF_MASK: s = PBC_SEL_MASK;
            default: s = PBC_SEL_NONE;
        endcase
        return s;
    endfunction

    // Places a port B field in bits 7 to 4 of a register word.
    function automatic logic [PBC_DATA_W-1:0] b_word(input logic [PBC_B_PINS-1:0] f);
        logic [PBC_DATA_W-1:0] w;
        w = PBC_DATA_ZERO;
        w[PBC_B_LSB +: PBC_B_PINS] = f;
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Edge detectors
    // ------------------------------------------------------------------
    // Each group gets its own synchroniser. An edge pulse arrives a few clock
    // edges after the pin moves, so pulses shorter than a clock period can be
    // missed; that is the price of sampling every pin on the one clock.
    pbc_edge_detect #(
        .WIDTH(PBC_B_PINS)
    ) u_edge_b (
        .pclk(pclk),
        .presetn(presetn),
        .pin(port_b_pin),
        .rise_det(b_rise_det),
        .fall_det(b_fall_det)
    );

    pbc_edge_detect #(
        .WIDTH(PBC_C_PINS)
    ) u_edge_c (
        .pclk(pclk),
        .presetn(presetn),
        .pin(port_c_pin),
        .rise_det(c_rise_det),
        .fall_det(c_fall_det)
    );

    // ------------------------------------------------------------------
    // Enable gating
    // ------------------------------------------------------------------
    // disabled edges dropped
    // A detected edge only counts where its direction is enabled.
    assign b_rise_hit = b_rise_det & r.b_rise;
    assign b_fall_hit = b_fall_det & r.b_fall;
    assign c_rise_hit = c_rise_det & r.c_rise;
    assign c_fall_hit = c_fall_det & r.c_fall;
    assign b_hit = b_rise_hit | b_fall_hit;
    assign c_hit = c_rise_hit | c_fall_hit;
    assign any_hit = (|b_hit) | (|c_hit);

    // ------------------------------------------------------------------
    // APB strobes
    // ------------------------------------------------------------------
    // Writes land only at the edge where the access phase sees pready high.
    assign sel = decode(paddr);
    assign commit = psel & penable & pwrite & r.pready & (sel != PBC_SEL_NONE);
    assign wr_b_flag = commit & (sel == PBC_SEL_B_FLAG);
    assign wr_c_flag = commit & (sel == PBC_SEL_C_FLAG);
    assign wr_status = commit & (sel == PBC_SEL_STATUS);

    // Read multiplexer; unimplemented bits are zero.
    always_comb begin
        read_data = PBC_DATA_ZERO;
        case (sel)
            PBC_SEL_B_RISE: read_data = b_word(r.b_rise);
            PBC_SEL_B_FALL: read_data = b_word(r.b_fall);
            PBC_SEL_B_FLAG: read_data = b_word(r.b_flag);
            PBC_SEL_C_RISE: read_data[PBC_C_PINS-1:0] = r.c_rise;
            PBC_SEL_C_FALL: read_data[PBC_C_PINS-1:0] = r.c_fall;
            PBC_SEL_C_FLAG: read_data[PBC_C_PINS-1:0] = r.c_flag;
            PBC_SEL_STATUS: read_data[PBC_STAT_CHANGE] = r.status;
            PBC_SEL_MASK: read_data[PBC_STAT_CHANGE] = r.mask;
            default: read_data = PBC_DATA_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        // One wait state: pready rises in the second access cycle, so the
        // read data and the error flag are registered like every output.
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.pslverr = (sel == PBC_SEL_NONE);
            next_r.prdata = pwrite ? PBC_DATA_ZERO : read_data;
        end else begin
            next_r.pready = 1'b0;
            next_r.pslverr = 1'b0;
        end

        if (commit && sel == PBC_SEL_B_RISE) begin
            next_r.b_rise = pwdata[PBC_B_LSB +: PBC_B_PINS];
        end
        if (commit && sel == PBC_SEL_B_FALL) begin
            next_r.b_fall = pwdata[PBC_B_LSB +: PBC_B_PINS];
        end
        if (commit && sel == PBC_SEL_C_RISE) begin
            next_r.c_rise = pwdata[PBC_C_PINS-1:0];
        end
        if (commit && sel == PBC_SEL_C_FALL) begin
            next_r.c_fall = pwdata[PBC_C_PINS-1:0];
        end
        if (commit && sel == PBC_SEL_MASK) begin
            next_r.mask = pwdata[PBC_STAT_CHANGE];
        end

        if (wr_b_flag) begin
            next_r.b_flag = pwdata[PBC_B_LSB +: PBC_B_PINS];
        end
        if (wr_c_flag) begin
            next_r.c_flag = pwdata[PBC_C_PINS-1:0];
        end

        // hardware set wins
        // The hardware set is ORed after the write so an edge landing in the
        // cycle of a clearing write is kept, not lost.
        next_r.b_flag = next_r.b_flag | b_hit;
        next_r.c_flag = next_r.c_flag | c_hit;

        // shared flag set
        // The shared flag is sticky and cleared by writing one; again the
        // set term is applied last so it beats a simultaneous clear.
        if (wr_status && pwdata[PBC_STAT_CHANGE]) begin
            next_r.status = 1'b0;
        end
        if (any_hit) begin
            next_r.status = 1'b1;
        end

        // Level interrupt, registered from the next status and mask.
        next_r.irq = next_r.status & next_r.mask;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // all bits reset zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign shared_change_interrupt_flag = r.status;
    assign irq = r.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_b_rise_flag: assert property ((b_rise_hit != '0) |=>
        ((r.b_flag & $past(b_rise_hit)) == $past(b_rise_hit)))
        else $error("Port B rising edge did not set its flag.");

    a_b_fall_flag: assert property ((b_fall_hit != '0) |=>
        ((r.b_flag & $past(b_fall_hit)) == $past(b_fall_hit)))
        else $error("Port B falling edge did not set its flag.");

    a_c_rise_flag: assert property ((c_rise_hit != '0) |=>
        ((r.c_flag & $past(c_rise_hit)) == $past(c_rise_hit)))
        else $error("Port C rising edge did not set its flag.");

    a_c_fall_flag: assert property ((c_fall_hit != '0) |=>
        ((r.c_flag & $past(c_fall_hit)) == $past(c_fall_hit)))
        else $error("Port C falling edge did not set its flag.");

    a_shared_flag_set: assert property ((c_hit != '0) |=> r.status ##1 r.irq == (r.status & r.mask))
        else $error("Port C edge did not set the shared flag.");

    a_disabled_no_flag: assert property ((!wr_c_flag && c_hit == '0) |=>
        ((r.c_flag & ~$past(r.c_flag)) == '0))
        else $error("Port C flag rose without an enabled edge.");

    a_sw_clear_flag: assert property ((wr_c_flag && pwdata == PBC_DATA_ZERO && c_hit == '0) |=>
        (r.c_flag == '0))
        else $error("Writing zero did not clear the port C flags.");

    a_set_beats_clear: assert property ((wr_b_flag && b_hit != '0) |=>
        ((r.b_flag & $past(b_hit)) == $past(b_hit)))
        else $error("Clearing write swallowed a port B edge.");

    a_b_low_zero: assert property ((r.pready && !pwrite && sel == PBC_SEL_B_FLAG) |->
        (r.prdata[PBC_B_LSB-1:0] == '0))
        else $error("Port B flag low bits read nonzero.");

    a_apb_one_wait: assert property ((psel && penable && !r.pready) |=> r.pready ##1 !r.pready)
        else $error("Access did not complete after one wait state.");

    a_irq_level: assert property (r.irq == (r.status & r.mask))
        else $error("Interrupt output disagrees with status and mask.");

    // Flags and the shared flag only fall through a software write, and the
    // bus answers an unmapped access with an error and zero data.
    a_status_sticky: assert property ((r.status && !(wr_status && pwdata[PBC_STAT_CHANGE])) |=> r.status)
        else $error("Shared flag fell without a clearing write.");

    a_b_shared_flag: assert property ((b_hit != '0) |=> r.status)
        else $error("Port B edge did not set the shared flag.");

    a_c_flag_hold: assert property (!wr_c_flag |=>
        ((~r.c_flag & $past(r.c_flag)) == '0))
        else $error("Port C flag fell without a write.");

    a_b_flag_hold: assert property (!wr_b_flag |=>
        ((~r.b_flag & $past(r.b_flag)) == '0))
        else $error("Port B flag fell without a write.");

    a_b_disabled_flag: assert property ((!wr_b_flag && b_hit == '0) |=>
        ((r.b_flag & ~$past(r.b_flag)) == '0))
        else $error("Port B flag rose without an enabled edge.");

    a_b_sw_clear: assert property ((wr_b_flag && pwdata == PBC_DATA_ZERO && b_hit == '0) |=>
        (r.b_flag == '0))
        else $error("Writing zero did not clear the port B flags.");

    a_unmapped_err: assert property ((psel && penable && !r.pready && sel == PBC_SEL_NONE) |=>
        (r.pready && r.pslverr))
        else $error("Unmapped access was not refused.");

    a_mapped_no_err: assert property ((psel && penable && !r.pready && sel != PBC_SEL_NONE) |=>
        (r.pready && !r.pslverr))
        else $error("Mapped access was refused.");

    a_err_data_zero: assert property ((r.pready && r.pslverr) |-> (r.prdata == PBC_DATA_ZERO))
        else $error("Refused access returned nonzero data.");

    c_port_c_edge: cover property ((c_rise_hit != '0) ##1 r.status);
    c_port_b_fall: cover property ((b_fall_hit != '0) ##1 (r.b_flag != '0));
    c_set_clear: cover property (wr_c_flag && c_hit != '0);
    c_irq_raise: cover property (!r.irq ##1 r.irq);
    c_bad_addr: cover property (r.pready && r.pslverr);

endmodule

/* File: pbc_change_detect_test.sv */
// Self-checking testbench for the port B and port C change detector.
module pbc_change_detect_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pbc_pkg::*;

    // ------------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PBC_ADDR_W-1:0] paddr = 8'h00;
    logic [PBC_DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [PBC_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [PBC_B_PINS-1:0] port_b_pin = 4'h0;
    logic [PBC_C_PINS-1:0] port_c_pin = 8'h00;
    logic shared_change_interrupt_flag;
    logic irq;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] bad_d;
    logic bad_e;

    pbc_change_detect u_pbc_change_detect (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_b_pin(port_b_pin), .port_c_pin(port_c_pin),
        .shared_change_interrupt_flag(shared_change_interrupt_flag), .irq(irq)
    );

    // The clock toggles every half period of 5 ns.
    always #5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    // Counts every comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run();
        $display("Checks made: %0d, mismatches: %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A hung access counts as a mismatch and ends the run at once.
        if (n >= 50) begin
            check(32'h0000_0000, 32'h0000_0001);
            complete_run();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic e;
        apb_xfer(1'b1, addr, data, d, e);
        check({31'h0, e}, 32'h0000_0000);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e;
        apb_xfer(1'b0, addr, 32'h0000_0000, d, e);
        check(d, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask

    // Outputs are looked at on the falling edge, well clear of any update.
    task automatic out_chk(input logic exp_flag, input logic exp_irq);
        @(negedge pclk);
        check({31'h0, shared_change_interrupt_flag}, {31'h0, exp_flag});
        check({31'h0, irq}, {31'h0, exp_irq});
    endtask

    // Changes one pin, then leaves room for the synchroniser and the flag to settle.
    task automatic set_pin(input logic is_b, input int i, input logic v);
        @(posedge pclk);
        if (is_b) begin
            port_b_pin[i] <= v;
        end else begin
            port_c_pin[i] <= v;
        end
        repeat (5) @(posedge pclk);
    endtask

    // Walks one pin through enabled and disabled edges of both directions.
    task automatic edge_case(input logic is_b, input int i);
        logic [31:0] m;
        logic [7:0] a_r;
        logic [7:0] a_f;
        logic [7:0] a_g;
        m = is_b ? 32'(1 << (i + PBC_B_LSB)) : 32'(1 << i);
        a_r = is_b ? PBC_OFF_B_RISE : PBC_OFF_C_RISE;
        a_f = is_b ? PBC_OFF_B_FALL : PBC_OFF_C_FALL;
        a_g = is_b ? PBC_OFF_B_FLAG : PBC_OFF_C_FLAG;
        wr(a_r, m);
        wr(a_f, 32'h0000_0000);
        set_pin(is_b, i, 1'b1);
        rd_chk(a_g, m, 1'b0);
        out_chk(1'b1, 1'b1);
        wr(a_g, 32'h0000_0000);
        wr(PBC_OFF_STATUS, 32'h0000_0001);
        set_pin(is_b, i, 1'b0);
        rd_chk(a_g, 32'h0000_0000, 1'b0);
        wr(a_r, 32'h0000_0000);
        wr(a_f, m);
        set_pin(is_b, i, 1'b1);
        rd_chk(a_g, 32'h0000_0000, 1'b0);
        out_chk(1'b0, 1'b0);
        set_pin(is_b, i, 1'b0);
        rd_chk(a_g, m, 1'b0);
        out_chk(1'b1, 1'b1);
        wr(a_g, 32'h0000_0000);
        wr(PBC_OFF_STATUS, 32'h0000_0001);
        wr(a_f, 32'h0000_0000);
        rd_chk(a_g, 32'h0000_0000, 1'b0);
        out_chk(1'b0, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    logic [7:0] offs [8] = '{PBC_OFF_B_RISE, PBC_OFF_B_FALL, PBC_OFF_B_FLAG, PBC_OFF_C_RISE,
                             PBC_OFF_C_FALL, PBC_OFF_C_FLAG, PBC_OFF_STATUS, PBC_OFF_MASK};
    // Values read back after writing all ones; status clears on a one.
    logic [31:0] ones_exp [8] = '{32'h0000_00F0, 32'h0000_00F0, 32'h0000_00F0, 32'h0000_00FF,
                                  32'h0000_00FF, 32'h0000_00FF, 32'h0000_0000, 32'h0000_0001};

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rd_chk(offs[k], 32'h0000_0000, 1'b0);
        end
        for (int k = 0; k < 8; k++) begin
            wr(offs[k], 32'hFFFF_FFFF);
            rd_chk(offs[k], ones_exp[k], 1'b0);
        end
        out_chk(1'b0, 1'b0);
        // An unmapped address is refused with an error and zero data.
        apb_xfer(1'b1, 8'h20, 32'hFFFF_FFFF, bad_d, bad_e);
        check({31'h0, bad_e}, 32'h0000_0001);
        rd_chk(8'h20, 32'h0000_0000, 1'b1);
        // a reset in mid-run clears everything again
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rd_chk(offs[k], 32'h0000_0000, 1'b0);
        end
        // A masked event sets the shared flag but holds the interrupt low.
        wr(PBC_OFF_C_RISE, 32'h0000_0001);
        set_pin(1'b0, 0, 1'b1);
        out_chk(1'b1, 1'b0);
        wr(PBC_OFF_MASK, 32'h0000_0001);
        out_chk(1'b1, 1'b1);
        wr(PBC_OFF_STATUS, 32'h0000_0001);
        out_chk(1'b0, 1'b0);
        set_pin(1'b0, 0, 1'b0);
        out_chk(1'b0, 1'b0);
        wr(PBC_OFF_C_FLAG, 32'h0000_0000);
        wr(PBC_OFF_C_RISE, 32'h0000_0000);
        // Every pin of both ports, mask left open.
        for (int i = 0; i < PBC_B_PINS; i++) begin
            edge_case(1'b1, i);
        end
        for (int i = 0; i < PBC_C_PINS; i++) begin
            edge_case(1'b0, i);
        end
        // an edge meeting a clearing write keeps its flag
        // The pin moves one edge before the write starts, so the edge pulse
        // and the write land at the same clock edge.
        wr(PBC_OFF_B_RISE, 32'h0000_0010);
        wr(PBC_OFF_C_RISE, 32'h0000_0001);
        wr(PBC_OFF_B_FLAG, 32'h0000_0080);
        @(posedge pclk);
        port_b_pin[0] <= 1'b1;
        wr(PBC_OFF_B_FLAG, 32'h0000_0000);
        rd_chk(PBC_OFF_B_FLAG, 32'h0000_0010, 1'b0);
        wr(PBC_OFF_C_FLAG, 32'h0000_0080);
        @(posedge pclk);
        port_c_pin[0] <= 1'b1;
        wr(PBC_OFF_C_FLAG, 32'h0000_0000);
        rd_chk(PBC_OFF_C_FLAG, 32'h0000_0001, 1'b0);
        complete_run();
    end

    // Cuts a hang short well beyond the roughly 1200 cycles the tests need.
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end
endmodule
